// *** hdl/clock_gen_defs.vh ***
// Functional notes
// - Bit 7 selects low power or high amplitude
// - Range bit: low gives P=64, high P=1
// - Range bit accepts only first write after reset
// - Range matters only in external-reference modes
// - Bit 5 selects external clock or crystal, write-once
// - Bits 4:3 choose one of four clock modes
// - Bypassed external waits for reference stable status
// - Off mode keeps the mode field unchanged
// - Field write ignored while earlier one pending
// - First mode write 0X blocks later 1X writes
// - Oscillator keep-on rules in off mode
// - Loss-of-clock disable bit turns detection off
// - Lock loss raises interrupt or reset request
// - Clock loss raises interrupt or reset request
// - Multiply code gives N from 4 to 18
// - Divide code gives R as two to the code
// - Reference status shows selected reference
// - Stable status high only when reference good
// - Lock loss status sticky until flag cleared
// - Bit 0 of first register reads zero
`ifndef CLOCK_GEN_DEFS_VH
`define CLOCK_GEN_DEFS_VH
`define CG_ADDR_CTRL1       2'h0
`define CG_ADDR_CTRL2       2'h1
`define CG_ADDR_STATUS      2'h2
`define CG_CTRL1_RESET      8'h00
`define CG_CTRL2_RESET      8'h00
`define CG_C1_HIGH_GAIN     7
`define CG_C1_RANGE         6
`define CG_C1_REF_SEL       5
`define CG_C1_MODE_HI       4
`define CG_C1_MODE_LO       3
`define CG_C1_KEEP_ON       2
`define CG_C1_LOC_DISABLE   1
`define CG_C2_LOL_RESET     7
`define CG_C2_MUL_HI        6
`define CG_C2_MUL_LO        4
`define CG_C2_LOC_RESET     3
`define CG_C2_DIV_HI        2
`define CG_C2_DIV_LO        0
`define CG_MODE_SELF        2'h0
`define CG_MODE_FEI         2'h1
`define CG_MODE_FBE         2'h2
`define CG_MODE_FEE         2'h3
`define CG_PRESCALE_LOW     7'h40
`define CG_PRESCALE_HIGH    7'h01
`define CG_SETTLE_NS        16
`define CG_CLK_PERIOD_NS    4
`endif

// *** hdl/input_sync.v ***
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module input_sync (
    input  wire clock_in,
    input  wire rst_n_in,
    input  wire async_in,
    output reg  sync_out
);
    reg stage1;
    reg stage2;
    reg stage3;

    // First stage feeds only the second
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1   <= 1'b0;
            stage2   <= 1'b0;
            stage3   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                sync_out <= stage3;
        end
    end
endmodule

// *** hdl/field_update.v ***
`timescale 1ns/1ps
`include "clock_gen_defs.vh"
// Holds one control field; a new write is refused until the last one settled
module field_update #(
    parameter WIDTH  = 3,
    parameter SETTLE = 4
) (
    input  wire             clock_in,
    input  wire             rst_n_in,
    input  wire             write_in,
    input  wire [WIDTH-1:0] data_in,
    output reg  [WIDTH-1:0] value_out,
    output wire             busy_out
);
    reg [7:0] settle_count;

    assign busy_out = (settle_count != 8'h00);

    // Settle counter models the cross-domain completion of the write
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out    <= {WIDTH{1'b0}};
            settle_count <= 8'h00;
        end else if (write_in && !busy_out) begin
            value_out    <= data_in;
            settle_count <= SETTLE[7:0];
        end else if (busy_out) begin
            settle_count <= settle_count - 8'h01;
        end
    end
endmodule

// *** hdl/clock_gen_control_regs.v ***
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "clock_gen_defs.vh"
// Control-register layer of the internal clock generator
module clock_gen_control_regs (
    input  wire       clock_in,
    input  wire       rst_n_in,
    // Avalon-MM slave
    input  wire [1:0] avs_address_in,
    input  wire       avs_read_in,
    input  wire       avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0] avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg        avs_waitrequest_out,
    // Analog and loop side
    input  wire       ext_ref_good_in,
    input  wire       osc_ready_in,
    input  wire       lock_loss_event_in,
    input  wire       clock_loss_event_in,
    input  wire       off_mode_in,
    input  wire       enable_in,
    output reg        osc_high_gain_out,
    output reg  [6:0] prescale_out,
    output reg        ext_reference_select_out,
    output reg  [1:0] clock_mode_out,
    output reg        osc_enable_out,
    output reg        clock_loss_detect_out,
    output reg  [4:0] multiply_n_out,
    output reg  [7:0] divide_r_out,
    output reg        irq_request_out,
    output reg        reset_request_out
);
    localparam SETTLE = (`CG_SETTLE_NS + `CG_CLK_PERIOD_NS - 1) / `CG_CLK_PERIOD_NS;

    // Software-held bits, write-once tracking, sticky status flags and bus handshake state
    reg       osc_high_gain_select;
    reg       range_bit;
    reg       ext_reference_select;
    reg       osc_keep_on_in_off_mode;
    reg       loss_of_clock_disable;
    reg       lock_loss_reset_enable;
    reg       clock_loss_reset_enable;
    reg       range_written;
    reg       ref_written;
    reg       mode_written;
    reg       ext_modes_blocked;
    reg [1:0] mode_request;
    reg       lock_loss_status;
    reg       clock_loss_status;
    reg       clock_gen_irq_flag;
    reg       ack_pending;

    wire       ext_ref_stable_status;
    wire       osc_ready_sync;
    wire [1:0] clock_mode_select;
    wire [2:0] fll_multiply_field;
    wire [2:0] output_divide_field;
    wire       mode_busy;
    wire       mul_busy;
    wire       div_busy;

    wire wr_c1 = avs_write_in && ack_pending && avs_byteenable_in[0]
                 && avs_address_in == `CG_ADDR_CTRL1;
    wire wr_c2 = avs_write_in && ack_pending && avs_byteenable_in[0]
                 && avs_address_in == `CG_ADDR_CTRL2;
    wire wr_st = avs_write_in && ack_pending && avs_byteenable_in[0]
                 && avs_address_in == `CG_ADDR_STATUS;
    wire [7:0] wd = avs_writedata_in[7:0];
    wire [1:0] wd_mode = wd[`CG_C1_MODE_HI:`CG_C1_MODE_LO];
    // Blocked modes are 1X after a first 0X write
    wire mode_allowed = !(wd_mode[1] && (ext_modes_blocked ||
                          (!mode_written && 1'b0)));
    wire mode_wr = wr_c1 && mode_allowed && !mode_busy;

    input_sync sync_ref (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (ext_ref_good_in),
        .sync_out (ext_ref_stable_status)
    );

    input_sync sync_osc (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (osc_ready_in),
        .sync_out (osc_ready_sync)
    );

    field_update #(.WIDTH(2), .SETTLE(SETTLE)) mode_field (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .write_in  (wr_c1 && mode_allowed),
        .data_in   (wd_mode),
        .value_out (clock_mode_select),
        .busy_out  (mode_busy)
    );

    field_update #(.WIDTH(3), .SETTLE(SETTLE)) mul_field (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .write_in  (wr_c2),
        .data_in   (wd[`CG_C2_MUL_HI:`CG_C2_MUL_LO]),
        .value_out (fll_multiply_field),
        .busy_out  (mul_busy)
    );

    field_update #(.WIDTH(3), .SETTLE(SETTLE)) div_field (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .write_in  (wr_c2),
        .data_in   (wd[`CG_C2_DIV_HI:`CG_C2_DIV_LO]),
        .value_out (output_divide_field),
        .busy_out  (div_busy)
    );

    // Bus handshake: one wait cycle per access, so each access takes two edges
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_pending         <= 1'b0;
            avs_waitrequest_out <= 1'b1;
        end else begin
            ack_pending         <= (avs_read_in || avs_write_in) && !ack_pending;
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_pending);
        end
    end

    // Plain control bits and write-once tracking
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_high_gain_select    <= 1'b0;
            range_bit               <= 1'b0;
            ext_reference_select    <= 1'b0;
            osc_keep_on_in_off_mode <= 1'b0;
            loss_of_clock_disable   <= 1'b0;
            lock_loss_reset_enable  <= 1'b0;
            clock_loss_reset_enable <= 1'b0;
            range_written           <= 1'b0;
            ref_written             <= 1'b0;
            mode_written            <= 1'b0;
            ext_modes_blocked       <= 1'b0;
        end else begin
            if (wr_c1) begin
                osc_high_gain_select    <= wd[`CG_C1_HIGH_GAIN];
                osc_keep_on_in_off_mode <= wd[`CG_C1_KEEP_ON];
                loss_of_clock_disable   <= wd[`CG_C1_LOC_DISABLE];
                range_written           <= 1'b1;
                ref_written             <= 1'b1;
                if (!range_written)
                    range_bit <= wd[`CG_C1_RANGE];
                if (!ref_written)
                    ext_reference_select <= wd[`CG_C1_REF_SEL];
                if (!mode_written) begin
                    mode_written      <= 1'b1;
                    ext_modes_blocked <= !wd_mode[1];
                end
            end
            if (wr_c2) begin
                lock_loss_reset_enable  <= wd[`CG_C2_LOL_RESET];
                clock_loss_reset_enable <= wd[`CG_C2_LOC_RESET];
            end
        end
    end

    // Sticky loss flags; a new event beats a software clear
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_loss_status   <= 1'b0;
            clock_loss_status  <= 1'b0;
            clock_gen_irq_flag <= 1'b0;
        end else begin
            if (lock_loss_event_in)
                lock_loss_status <= 1'b1;
            else if (wr_st && wd[0])
                lock_loss_status <= 1'b0;
            // Clear does not wait for the flag: a reset-routed loss never raises it
            if (clock_loss_event_in && !loss_of_clock_disable)
                clock_loss_status <= 1'b1;
            else if (wr_st && wd[0])
                clock_loss_status <= 1'b0;
            if ((lock_loss_event_in && !lock_loss_reset_enable) ||
                (clock_loss_event_in && !loss_of_clock_disable && !clock_loss_reset_enable))
                clock_gen_irq_flag <= 1'b1;
            else if (wr_st && wd[0])
                clock_gen_irq_flag <= 1'b0;
        end
    end

    // Outputs derived from fields, all registered
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_high_gain_out        <= 1'b0;
            prescale_out             <= `CG_PRESCALE_HIGH;
            ext_reference_select_out <= 1'b0;
            clock_mode_out           <= `CG_MODE_SELF;
            osc_enable_out           <= 1'b0;
            clock_loss_detect_out    <= 1'b0;
            multiply_n_out           <= 5'h04;
            divide_r_out             <= 8'h01;
            irq_request_out          <= 1'b0;
            reset_request_out        <= 1'b0;
        end else begin
            osc_high_gain_out        <= osc_high_gain_select;
            ext_reference_select_out <= ext_reference_select;
            clock_loss_detect_out    <= !loss_of_clock_disable;
            // Prescale applies only with an external reference
            if (clock_mode_select[1])
                prescale_out <= range_bit ? `CG_PRESCALE_HIGH : `CG_PRESCALE_LOW;
            else
                prescale_out <= `CG_PRESCALE_HIGH;
            // Mode field is held in off mode; bypass waits for a stable reference
            if (off_mode_in)
                clock_mode_out <= clock_mode_out;
            else if (clock_mode_select == `CG_MODE_FBE && !ext_ref_stable_status)
                clock_mode_out <= clock_mode_out;
            else
                clock_mode_out <= clock_mode_select;
            if (!off_mode_in)
                osc_enable_out <= clock_mode_select[1] && ext_reference_select && osc_ready_sync;
            else if (osc_keep_on_in_off_mode)
                osc_enable_out <= clock_mode_select[1] && ext_reference_select;
            else
                osc_enable_out <= enable_in && clock_mode_select == `CG_MODE_FBE
                                  && ext_reference_select;
            multiply_n_out    <= {1'b0, fll_multiply_field, 1'b0} + 5'h04;
            divide_r_out      <= 8'h01 << output_divide_field;
            irq_request_out   <= clock_gen_irq_flag;
            reset_request_out <= (lock_loss_status && lock_loss_reset_enable)
                              || (clock_loss_status && clock_loss_reset_enable);
        end
    end

    // Read mux; unmapped addresses read zero
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && !ack_pending) begin
            case (avs_address_in)
                `CG_ADDR_CTRL1: avs_readdata_out <= {24'h000000, osc_high_gain_select, range_bit,
                    ext_reference_select, clock_mode_select, osc_keep_on_in_off_mode,
                    loss_of_clock_disable, 1'b0};
                `CG_ADDR_CTRL2: avs_readdata_out <= {24'h000000, lock_loss_reset_enable,
                    fll_multiply_field, clock_loss_reset_enable, output_divide_field};
                `CG_ADDR_STATUS: avs_readdata_out <= {24'h000000, clock_mode_out,
                    ext_reference_select, lock_loss_status, mode_busy | mul_busy | div_busy,
                    clock_loss_status, ext_ref_stable_status, clock_gen_irq_flag};
                default: avs_readdata_out <= 32'h00000000;
            endcase
        end
    end
endmodule

// *** verif/clock_gen_control_regs_properties.sv ***
`timescale 1ns/1ps
module clock_gen_control_regs_properties (
    input wire        clock_in,
    input wire        rst_n_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        ext_ref_good_in,
    input wire        off_mode_in,
    input wire [6:0]  prescale_out,
    input wire [1:0]  clock_mode_out,
    input wire [4:0]  multiply_n_out,
    input wire [7:0]  divide_r_out,
    input wire        irq_request_out,
    input wire        reset_request_out
);
    // One clock domain; reset silences every check
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    chk_bus_answer_next: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("waitrequest not low one cycle after request");
    chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    chk_upper_lanes_zero: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    chk_reset_values: assert property (!$past(rst_n_in) |-> multiply_n_out == 5'h04
        && divide_r_out == 8'h01 && clock_mode_out == 2'h0) else $error("bad values after reset");
    chk_multiply_legal: assert property (multiply_n_out >= 5'h04 && multiply_n_out <= 5'h12
        && !multiply_n_out[0]) else $error("multiply factor outside 4 to 18");
    chk_divide_power: assert property ($onehot(divide_r_out))
        else $error("divide factor not a power of two");
    chk_prescale_legal: assert property (prescale_out == 7'h40 || prescale_out == 7'h01)
        else $error("prescale neither 64 nor 1");
    // The stable level crosses four flops, so it must have been high three edges before
    chk_bypass_waits: assert property ($rose(clock_mode_out == 2'h2) |-> $past(ext_ref_good_in, 3))
        else $error("bypass mode entered before reference stable");
    chk_field_settle: assert property ($changed(multiply_n_out) |=> $stable(multiply_n_out) [*2])
        else $error("multiply field changed while settling");
    chk_off_keeps_mode: assert property ($rose(off_mode_in) |=> $stable(clock_mode_out))
        else $error("mode changed on entry to off mode");
    cover property ($rose(clock_mode_out == 2'h2));
    cover property ($rose(irq_request_out));
    cover property ($rose(reset_request_out));
endmodule

// *** verif/ext_ref_crystal_model.sv ***
`timescale 1ns/1ps
// Crystal that needs a start-up time once requested; dropping the request kills it on the next clock edge
module ext_ref_crystal_model #(
    parameter STARTUP = 24
) (
    input  wire clock_in,
    input  wire rst_n_in,
    input  wire request_in,
    output reg  osc_ready_out,
    output reg  ext_ref_good_out
);
    integer run;
    // Amplitude comes up first, frequency qualifies later
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in || !request_in) begin
            run <= 0;
            osc_ready_out <= 1'b0;
            ext_ref_good_out <= 1'b0;
        end else begin
            if (run < STARTUP) run <= run + 1;
            osc_ready_out <= (run >= STARTUP / 2);
            ext_ref_good_out <= (run >= STARTUP);
        end
    end
endmodule

// *** verif/clock_gen_control_regs_bench.sv ***
`timescale 1ns/1ps
bind clock_gen_control_regs clock_gen_control_regs_properties props_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ext_ref_good_in(ext_ref_good_in),
    .off_mode_in(off_mode_in), .prescale_out(prescale_out), .clock_mode_out(clock_mode_out),
    .multiply_n_out(multiply_n_out), .divide_r_out(divide_r_out),
    .irq_request_out(irq_request_out), .reset_request_out(reset_request_out));
module clock_gen_control_regs_bench;
    reg         clock_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    reg  [1:0]  avs_address_in = 2'h0;
    reg  [31:0] avs_writedata_in = 32'h0;
    reg  [3:0]  avs_byteenable_in = 4'h0;
    reg         lock_loss_event_in = 1'b0, clock_loss_event_in = 1'b0;
    reg         off_mode_in = 1'b0, enable_in = 1'b0;
    wire [31:0] avs_readdata_out;
    wire [6:0]  prescale_out;
    wire [1:0]  clock_mode_out;
    wire [4:0]  multiply_n_out;
    wire [7:0]  divide_r_out;
    wire        avs_waitrequest_out, ext_ref_good_in, osc_ready_in, osc_high_gain_out;
    wire        ext_reference_select_out, osc_enable_out, clock_loss_detect_out;
    wire        irq_request_out, reset_request_out;
    reg  [7:0]  rdata, v;
    integer     miscompares = 0, n_compared = 0, i, r, seed;
    clock_gen_control_regs clock_gen_control_regs_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .ext_ref_good_in(ext_ref_good_in), .osc_ready_in(osc_ready_in),
        .lock_loss_event_in(lock_loss_event_in), .clock_loss_event_in(clock_loss_event_in),
        .off_mode_in(off_mode_in), .enable_in(enable_in), .osc_high_gain_out(osc_high_gain_out),
        .prescale_out(prescale_out), .ext_reference_select_out(ext_reference_select_out),
        .clock_mode_out(clock_mode_out), .osc_enable_out(osc_enable_out),
        .clock_loss_detect_out(clock_loss_detect_out), .multiply_n_out(multiply_n_out),
        .divide_r_out(divide_r_out), .irq_request_out(irq_request_out),
        .reset_request_out(reset_request_out));
    ext_ref_crystal_model #(.STARTUP(24)) ext_ref_crystal_model_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .request_in(ext_reference_select_out),
        .osc_ready_out(osc_ready_in), .ext_ref_good_out(ext_ref_good_in));
    // 250 MHz bus clock
    always #2 clock_in = ~clock_in;
    task close_out;
        begin
            $display("compared %0d miscompares %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task cmp(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clock_in);
    endtask
    // Request held until the edge that samples waitrequest low; data taken there
    task bus(input rd, input [1:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge clock_in);
            avs_address_in <= a;
            avs_read_in <= rd;
            avs_write_in <= !rd;
            avs_writedata_in <= {24'h0, d};
            avs_byteenable_in <= 4'h1;
            n = 0;
            @(posedge clock_in);
            while (avs_waitrequest_out !== 1'b0 && n < 50) begin
                @(posedge clock_in);
                n = n + 1;
            end
            cmp("bus_timeout", 0, n >= 50);
            rdata = avs_readdata_out[7:0];
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask
    task wait_mode(input [1:0] m);
        for (i = 0; i < 200 && clock_mode_out !== m; i = i + 1) @(posedge clock_in);
    endtask
    task check_reset;
        begin
            bus(1, 2'h0, 8'h0);
            cmp("ctrl1_reset", 8'h00, rdata);
            bus(1, 2'h1, 8'h0);
            cmp("ctrl2_reset", 8'h00, rdata);
            cmp("n_reset", 4, multiply_n_out);
            cmp("r_reset", 1, divide_r_out);
            cmp("mode_reset", 0, clock_mode_out);
        end
    endtask
    // One loss event with a chosen routing, then the flag is cleared through status
    task loss(input lol, input k);
        begin
            bus(0, 2'h1, {k, 3'h0, k, 3'h0});
            cyc(6);
            @(posedge clock_in);
            if (lol) lock_loss_event_in <= 1'b1;
            else clock_loss_event_in <= 1'b1;
            @(posedge clock_in);
            lock_loss_event_in <= 1'b0;
            clock_loss_event_in <= 1'b0;
            cyc(5);
            cmp("irq_req", !k, irq_request_out);
            cmp("rst_req", k, reset_request_out);
            bus(1, 2'h2, 8'h0);
            cmp("loss_flag", 1, lol ? rdata[4] : rdata[2]);
            bus(0, 2'h2, 8'h01);
            cyc(4);
            cmp("irq_cleared", 0, irq_request_out | reset_request_out);
        end
    endtask
    initial begin
        seed = 32'h7a4d;
        cyc(12);
        rst_n_in <= 1'b1;
        check_reset;
        bus(0, 2'h0, 8'h31);
        bus(1, 2'h0, 8'h0);
        cmp("ctrl1", 8'h30, rdata);
        wait_mode(2'h2);
        cmp("mode_fbe", 2, clock_mode_out);
        cmp("prescale_low", 7'h40, prescale_out);
        cmp("gain_low", 0, osc_high_gain_out);
        bus(1, 2'h2, 8'h0);
        cmp("stable", 1, rdata[1]);
        cmp("ref_status", 1, rdata[5]);
        bus(0, 2'h0, 8'hd2);
        cyc(6);
        bus(1, 2'h0, 8'h0);
        cmp("ctrl1_once", 8'hb2, rdata);
        cmp("prescale_kept", 7'h40, prescale_out);
        cmp("gain_high", 1, osc_high_gain_out);
        cmp("detect_off", 0, clock_loss_detect_out);
        enable_in <= 1'b1;
        off_mode_in <= 1'b1;
        cyc(6);
        cmp("osc_on", 1, osc_enable_out);
        enable_in <= 1'b0;
        cyc(6);
        cmp("osc_off", 0, osc_enable_out);
        bus(1, 2'h0, 8'h0);
        cmp("mode_off", 2, rdata[4:3]);
        off_mode_in <= 1'b0;
        for (r = 0; r < 8; r = r + 1) begin
            i = $random(seed);
            v = {i[7], r[2:0], i[3], 3'h7 - r[2:0]};
            bus(0, 2'h1, v);
            cyc(6);
            cmp("n", 4 + 2 * r, multiply_n_out);
            cmp("r", 1 << (7 - r), divide_r_out);
            bus(1, 2'h1, 8'h0);
            cmp("ctrl2", v, rdata);
        end
        bus(0, 2'h1, 8'h00);
        bus(0, 2'h1, 8'h77);
        cyc(6);
        cmp("n_busy", 4, multiply_n_out);
        cmp("r_busy", 1, divide_r_out);
        bus(0, 2'h0, 8'hb0);
        cyc(6);
        cmp("detect_on", 1, clock_loss_detect_out);
        for (r = 0; r < 4; r = r + 1) loss(r[1], r[0]);
        bus(0, 2'h3, 8'hff);
        bus(1, 2'h3, 8'h0);
        cmp("unmapped", 0, rdata);
        rst_n_in <= 1'b0;
        cyc(3);
        rst_n_in <= 1'b1;
        check_reset;
        bus(0, 2'h0, 8'h08);
        cyc(6);
        cmp("mode_fei", 1, clock_mode_out);
        bus(0, 2'h0, 8'h18);
        cyc(6);
        cmp("mode_blocked", 1, clock_mode_out);
        bus(0, 2'h0, 8'h00);
        cyc(6);
        cmp("mode_self", 0, clock_mode_out);
        rst_n_in <= 1'b0;
        cyc(3);
        rst_n_in <= 1'b1;
        bus(0, 2'h0, 8'h78);
        wait_mode(2'h3);
        cmp("mode_fee", 3, clock_mode_out);
        cmp("prescale_high", 7'h01, prescale_out);
        close_out;
    end
    // Whole run needs a few hundred cycles
    initial begin
        #100000;
        miscompares = miscompares + 1;
        close_out;
    end
endmodule
